// ===== pkg/icc_pkg.sv
// Package of register map, field layout, reset values and timing for the I2C control block
package icc_pkg;

   // Register offsets on the local register port
   localparam logic [7:0] REG_I2C_CONTROL_ADDR    = 8'h05;
   localparam logic [7:0] REG_REMOTE_DES_ADDR     = 8'h06;

   // Reset values
   localparam logic [7:0] I2C_CONTROL_RST         = 8'h00;
   localparam logic [7:0] REMOTE_DES_ADDR_RST     = 8'h00;

   // Field positions of i2c_control
   localparam int unsigned CTL_SDA_DLY_LSB        = 3;
   localparam int unsigned CTL_SDA_DLY_W          = 2;
   localparam int unsigned CTL_WR_DIS_BIT         = 2;
   localparam int unsigned CTL_SPEEDUP_BIT        = 1;
   localparam int unsigned CTL_WD_DIS_BIT         = 0;

   // Field positions of remote_deserializer_address
   localparam int unsigned RDA_ADDR_LSB           = 1;
   localparam int unsigned RDA_ADDR_W             = 7;
   localparam int unsigned RDA_HOLD_BIT           = 0;

   // Clock
   localparam int unsigned CLK_PERIOD_NS          = 5;

   // SDA output delay after SCL falls: base plus steps
   localparam int unsigned SDA_BASE_NS            = 240;
   localparam int unsigned SDA_STEP_NS            = 40;
   localparam int unsigned SDA_BASE_CYC           = (SDA_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SDA_STEP_CYC           = (SDA_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SDA_CNT_W              = 7;

   // Bus watchdog timeouts
   localparam int unsigned WDOG_LONG_NS           = 1_000_000_000;
   localparam int unsigned WDOG_SHORT_NS          = 50_000;
   localparam int unsigned WDOG_LONG_CYC          = WDOG_LONG_NS / CLK_PERIOD_NS;
   localparam int unsigned WDOG_SHORT_CYC         = WDOG_SHORT_NS / CLK_PERIOD_NS;
   localparam int unsigned WDOG_CNT_W             = 28;

   // Bus recovery clocking: half period of each SCL pulse, and pulse count
   localparam int unsigned RECOV_HALF_NS          = 5_000;
   localparam int unsigned RECOV_HALF_CYC         = RECOV_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned RECOV_DIV_W            = 10;
   localparam logic [3:0]  RECOV_PULSES           = 4'h9;

   // Cycles from SCL falling to SDA update for a delay code
   function automatic logic [SDA_CNT_W-1:0] icc_sda_delay_cycles(
      input logic [CTL_SDA_DLY_W-1:0] code);
      icc_sda_delay_cycles = SDA_CNT_W'(SDA_BASE_CYC + SDA_STEP_CYC * int'(code));
   endfunction : icc_sda_delay_cycles

endpackage : icc_pkg

// ===== pkg/icc_wdog_if.sv
// Interface between the configuration block and its bus watchdog
`timescale 1ns/1ps
`default_nettype none
interface icc_wdog_if;
   logic speedup;     // Short timeout selected
   logic wd_off;      // Watchdog switched off
   logic scl_in;      // Sampled SCL level
   logic sda_in;      // Sampled SDA level
   logic bus_free;    // Bus judged free after idle with SDA high
   logic recovering;  // Recovery clocking in progress
   logic scl_oe_n;    // Low while SCL is pulled low

   modport ctl (output speedup, wd_off, scl_in, sda_in, input bus_free, recovering, scl_oe_n);
   modport wdog (input speedup, wd_off, scl_in, sda_in, output bus_free, recovering, scl_oe_n);
endinterface : icc_wdog_if
`default_nettype wire

// ===== rtl/icc_i2c_watchdog.sv
// I2C bus watchdog with idle detection and nine-pulse bus recovery
`timescale 1ns/1ps
`default_nettype none
module icc_i2c_watchdog
   import icc_pkg::*;
#(
   parameter int unsigned LONG_CYCLES  = WDOG_LONG_CYC,
   parameter int unsigned SHORT_CYCLES = WDOG_SHORT_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst,
   icc_wdog_if.wdog  wif
);

   // Whole state of the watchdog
   typedef struct packed {
      logic [WDOG_CNT_W-1:0]  cnt;       // Idle cycles seen
      logic                   scl_prev;  // SCL one cycle ago
      logic                   sda_prev;  // SDA one cycle ago
      logic                   free;      // Bus judged free
      logic                   recov;     // Recovery running
      logic [3:0]             pulses;    // Recovery pulses completed
      logic [RECOV_DIV_W-1:0] div;       // Half-period divider
      logic                   scl_oe_n;  // SCL pull-down, low active
   } icc_wdog_state_t;

   icc_wdog_state_t s_q;  // Registered state
   icc_wdog_state_t s_d;  // Next state

   logic                  activity;  // Any edge on SCL or SDA
   logic [WDOG_CNT_W-1:0] limit;     // Last count before expiry

   // Next state
   always_comb begin
      s_d          = s_q;
      s_d.scl_prev = wif.scl_in;
      s_d.sda_prev = wif.sda_in;
      activity     = (wif.scl_in != s_q.scl_prev) || (wif.sda_in != s_q.sda_prev);
      limit        = wif.speedup ? WDOG_CNT_W'(SHORT_CYCLES - 1)
                                 : WDOG_CNT_W'(LONG_CYCLES - 1);
      if (wif.wd_off) begin
         // Switched off: no count, no verdict, bus released
         s_d.cnt      = '0;
         s_d.free     = 1'b0;
         s_d.recov    = 1'b0;
         s_d.scl_oe_n = 1'b1;
      end else if (s_q.recov) begin
         // Our own SCL edges are not counted as activity here
         if (s_q.div == '0) begin
            s_d.div      = RECOV_DIV_W'(RECOV_HALF_CYC - 1);
            s_d.scl_oe_n = ~s_q.scl_oe_n;
            if (!s_q.scl_oe_n) begin
               // A release ends one pulse
               if (s_q.pulses == RECOV_PULSES - 4'h1) begin
                  s_d.recov  = 1'b0;
                  s_d.pulses = '0;
                  s_d.cnt    = '0;
               end else begin
                  s_d.pulses = s_q.pulses + 4'h1;
               end
            end
         end else begin
            s_d.div = s_q.div - RECOV_DIV_W'(1);
         end
      end else if (activity) begin
         // Any bus edge restarts the timeout
         s_d.cnt  = '0;
         s_d.free = 1'b0;
      end else if (s_q.cnt >= limit) begin
         s_d.cnt = '0;
         if (wif.sda_in) begin
            s_d.free = 1'b1;
         end else begin
            // SDA stuck low: clock the bus free
            s_d.recov    = 1'b1;
            s_d.scl_oe_n = 1'b0;
            s_d.pulses   = '0;
            s_d.div      = RECOV_DIV_W'(RECOV_HALF_CYC - 1);
         end
      end else begin
         s_d.cnt = s_q.cnt + WDOG_CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q          <= '0;
         s_q.scl_prev <= 1'b1;
         s_q.sda_prev <= 1'b1;
         s_q.scl_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Results back to the configuration block
   assign wif.bus_free   = s_q.free;
   assign wif.recovering = s_q.recov;
   assign wif.scl_oe_n   = s_q.scl_oe_n;

endmodule : icc_i2c_watchdog
`default_nettype wire

// ===== rtl/icc_i2c_control_channel_config.sv
// Local I2C control settings: SDA delay, write blocking, watchdog, remote address
//
// Overview of operation
// - SDA output delayed 240 to 360 ns
// - Local write disable rejects remote register writes
// - Remote access to local slaves stays allowed
// - Watchdog timeout 1 s, or 50 us sped up
// - Watchdog disable bit turns watchdog off
// - Idle with SDA high means bus free
// - Idle with SDA low: nine SCL pulses
// - Seven-bit remote address; zero blocks access
// - Address auto-loaded after receiver lock
// - Hold bit stops auto-loading
// - Port select maps address to second port
`timescale 1ns/1ps
`default_nettype none
module icc_i2c_control_channel_config
   import icc_pkg::*;
#(
   parameter int unsigned WDOG_LONG_CYCLES  = WDOG_LONG_CYC,
   parameter int unsigned WDOG_SHORT_CYCLES = WDOG_SHORT_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic       reg_remote,
   input  wire logic       second_port_select,
   input  wire logic [1:0] rx_lock,
   input  wire logic       auto_addr_valid,
   input  wire logic       auto_addr_port,
   input  wire logic [6:0] auto_addr,
   input  wire logic       sda_tx_data,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            scl_oe_n,
   output logic            sda_o,
   output logic            sda_oe_n,
   output logic [7:0]      reg_rdata,
   output logic            reg_rdata_valid,
   output logic            reg_wr_rejected,
   output logic [6:0]      remote_addr_port0,
   output logic [6:0]      remote_addr_port1,
   output logic [1:0]      remote_access_enable,
   output logic            bus_free,
   output logic            bus_recovering
);

   // Refuse watchdog counts that the counter cannot hold
   if (WDOG_LONG_CYCLES >= (1 << WDOG_CNT_W) || WDOG_SHORT_CYCLES < 2 ||
       WDOG_SHORT_CYCLES > WDOG_LONG_CYCLES) begin : g_bad_wdog
      $error("Watchdog cycle counts out of range");
   end

   // Whole state of the block
   typedef struct packed {
      logic [CTL_SDA_DLY_W-1:0]       sda_dly;   // SDA delay code
      logic                           wr_dis;    // Remote local-write disable
      logic                           speedup;   // Short watchdog timeout
      logic                           wd_off;    // Watchdog disabled
      logic [1:0][RDA_ADDR_W-1:0]     addr;      // Remote address per port
      logic [1:0]                     hold;      // Hold bit per port
      logic [1:0]                     acc_en;    // Remote access allowed per port
      logic [7:0]                     rdata;     // Read data
      logic                           rvalid;    // Read data strobe
      logic                           rej;       // Rejected-write strobe
      logic [SDA_CNT_W-1:0]           sda_cnt;   // Delay countdown
      logic                           sda_pend;  // SDA update pending
      logic                           sda_oe_n;  // SDA pull-down, low active
      logic                           scl_prev;  // SCL one cycle ago
      logic                           drv_lvl;   // Level driven when enabled
   } icc_state_t;

   icc_state_t s_q;  // Registered state
   icc_state_t s_d;  // Next state

   logic psel;       // Port that register 0x06 refers to
   logic local_hit;  // Access targets a register of this block
   logic scl_fall;   // SCL seen going low

   icc_wdog_if wif ();  // Link to the watchdog

   // Watchdog instance
   icc_i2c_watchdog #(
      .LONG_CYCLES  (WDOG_LONG_CYCLES),
      .SHORT_CYCLES (WDOG_SHORT_CYCLES)
   ) u_wdog (
      .core_clk (core_clk),
      .rst      (rst),
      .wif      (wif)
   );

   // Settings and sampled pins towards the watchdog
   assign wif.speedup = s_q.speedup;
   assign wif.wd_off  = s_q.wd_off;
   assign wif.scl_in  = scl_i;
   assign wif.sda_in  = sda_i;

   // Register read mux
   function automatic logic [7:0] read_reg(input icc_state_t s, input logic [7:0] a,
                                           input logic p);
      read_reg = 8'h00;
      if (a == REG_I2C_CONTROL_ADDR) begin
         // Reserved upper bits read as zero
         read_reg[CTL_SDA_DLY_LSB +: CTL_SDA_DLY_W] = s.sda_dly;
         read_reg[CTL_WR_DIS_BIT]                   = s.wr_dis;
         read_reg[CTL_SPEEDUP_BIT]                  = s.speedup;
         read_reg[CTL_WD_DIS_BIT]                   = s.wd_off;
      end else if (a == REG_REMOTE_DES_ADDR) begin
         read_reg[RDA_ADDR_LSB +: RDA_ADDR_W] = s.addr[p];
         read_reg[RDA_HOLD_BIT]               = s.hold[p];
      end
   endfunction : read_reg

   // Next state
   always_comb begin
      s_d        = s_q;
      s_d.rvalid = 1'b0;
      s_d.rej    = 1'b0;
      psel       = second_port_select;
      local_hit  = (reg_addr == REG_I2C_CONTROL_ADDR) || (reg_addr == REG_REMOTE_DES_ADDR);
      scl_fall   = s_q.scl_prev && !scl_i;
      s_d.scl_prev = scl_i;

      // Auto-load from the control channel once the receiver is locked
      for (int p = 0; p < 2; p++) begin
         if (auto_addr_valid && (auto_addr_port == p[0]) && rx_lock[p]) begin
            if (!s_q.hold[p]) begin
               s_d.addr[p] = auto_addr;
            end
         end
      end

      // Register writes; a software write wins over a same-cycle auto-load
      if (reg_wr && local_hit) begin
         if (reg_remote && s_q.wr_dis) begin
            // Only this register space is guarded; pass-through traffic to
            // slaves on this side never arrives on this port
            s_d.rej = 1'b1;
         end else if (reg_addr == REG_I2C_CONTROL_ADDR) begin
            s_d.sda_dly = reg_wdata[CTL_SDA_DLY_LSB +: CTL_SDA_DLY_W];
            s_d.wr_dis  = reg_wdata[CTL_WR_DIS_BIT];
            s_d.speedup = reg_wdata[CTL_SPEEDUP_BIT];
            s_d.wd_off  = reg_wdata[CTL_WD_DIS_BIT];
         end else begin
            s_d.addr[psel] = reg_wdata[RDA_ADDR_LSB +: RDA_ADDR_W];
            s_d.hold[psel] = reg_wdata[RDA_HOLD_BIT];
         end
      end

      // Zero address blocks remote access on that port
      for (int p = 0; p < 2; p++) begin
         s_d.acc_en[p] = (s_d.addr[p] != '0);
      end

      // Register reads answer one cycle later
      if (reg_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = read_reg(s_q, reg_addr, psel);
      end

      // SDA output follows the engine level only after the set delay from SCL low
      if (scl_fall) begin
         s_d.sda_cnt  = icc_sda_delay_cycles(s_q.sda_dly);
         s_d.sda_pend = 1'b1;
      end else if (s_q.sda_pend) begin
         if (s_q.sda_cnt == SDA_CNT_W'(1)) begin
            s_d.sda_oe_n = sda_tx_data;
            s_d.sda_pend = 1'b0;
         end else begin
            s_d.sda_cnt = s_q.sda_cnt - SDA_CNT_W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q          <= '0;
         s_q.sda_dly  <= I2C_CONTROL_RST[CTL_SDA_DLY_LSB +: CTL_SDA_DLY_W];
         s_q.wr_dis   <= I2C_CONTROL_RST[CTL_WR_DIS_BIT];
         s_q.speedup  <= I2C_CONTROL_RST[CTL_SPEEDUP_BIT];
         s_q.wd_off   <= I2C_CONTROL_RST[CTL_WD_DIS_BIT];
         s_q.addr[0]  <= REMOTE_DES_ADDR_RST[RDA_ADDR_LSB +: RDA_ADDR_W];
         s_q.addr[1]  <= REMOTE_DES_ADDR_RST[RDA_ADDR_LSB +: RDA_ADDR_W];
         s_q.hold     <= {2{REMOTE_DES_ADDR_RST[RDA_HOLD_BIT]}};
         s_q.sda_oe_n <= 1'b1;
         s_q.scl_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs, all from flip-flops; pins are open drain so driven level is low
   assign scl_o                = s_q.drv_lvl;
   assign scl_oe_n             = wif.scl_oe_n;
   assign sda_o                = s_q.drv_lvl;
   assign sda_oe_n             = s_q.sda_oe_n;
   assign reg_rdata            = s_q.rdata;
   assign reg_rdata_valid      = s_q.rvalid;
   assign reg_wr_rejected      = s_q.rej;
   assign remote_addr_port0    = s_q.addr[0];
   assign remote_addr_port1    = s_q.addr[1];
   assign remote_access_enable = s_q.acc_en;
   assign bus_free             = wif.bus_free;
   assign bus_recovering       = wif.recovering;

endmodule : icc_i2c_control_channel_config
`default_nettype wire

// ===== bench/icc_far_model.sv
// Far side model: I2C host wires with pull-ups and the remote deserializer address feed
`timescale 1ns/1ps
`default_nettype none
module icc_far_model (
   input  wire logic  core_clk,
   input  wire logic  scl_oe_n,
   input  wire logic  sda_oe_n,
   output logic       scl_i,
   output logic       sda_i,
   output logic       auto_addr_valid,
   output logic       auto_addr_port,
   output logic [6:0] auto_addr
);
   logic host_scl_low = 1'b0;  // Local host pulls SCL low
   logic host_sda_low = 1'b0;  // Local host pulls SDA low

   // Open-drain wires: the pull-up wins unless some party pulls low
   assign scl_i = scl_oe_n & ~host_scl_low;
   assign sda_i = sda_oe_n & ~host_sda_low;

   // Feed idle at time zero
   initial begin
      auto_addr_valid = 1'b0;
      auto_addr_port  = 1'b0;
      auto_addr       = 7'h00;
   end

   task automatic set_scl(input logic lvl);
      @(posedge core_clk);
      host_scl_low <= ~lvl;
   endtask : set_scl

   task automatic set_sda(input logic lvl);
      @(posedge core_clk);
      host_sda_low <= ~lvl;
   endtask : set_sda

   // One-cycle address delivery; the data is scrambled after so nothing stale lingers
   task automatic deliver(input logic port, input logic [6:0] addr);
      @(posedge core_clk);
      auto_addr_valid <= 1'b1;
      auto_addr_port  <= port;
      auto_addr       <= addr;
      @(posedge core_clk);
      auto_addr_valid <= 1'b0;
      auto_addr       <= ~addr;
   endtask : deliver
endmodule : icc_far_model
`default_nettype wire

// ===== bench/icc_i2c_props.sv
// Port checker of the I2C control block
`timescale 1ns/1ps
`default_nettype none
module icc_i2c_props
   import icc_pkg::*;
#(
   parameter int unsigned WDOG_LONG_CYCLES  = 40,
   parameter int unsigned WDOG_SHORT_CYCLES = 8
) (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       reg_remote,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       scl_oe_n,
   input wire logic       sda_oe_n,
   input wire logic       reg_rdata_valid,
   input wire logic       reg_wr_rejected,
   input wire logic [6:0] remote_addr_port0,
   input wire logic [6:0] remote_addr_port1,
   input wire logic [1:0] remote_access_enable,
   input wire logic       bus_free,
   input wire logic       bus_recovering
);
   logic [4:0]  ctl_q;   // Control bits as last accepted
   logic        scl_q;   // SCL one cycle earlier
   logic        sda_q;   // SDA one cycle earlier
   int unsigned fall_q;  // Cycles since SCL fell
   int unsigned idle_q;  // Cycles without bus activity
   logic [3:0]  rel_q;   // SCL releases within one recovery
   logic        rej_wr;  // Remote write that must be refused
   int unsigned lim;     // Timeout now selected
   assign rej_wr = reg_wr && reg_remote && ctl_q[2]
                   && (reg_addr == REG_I2C_CONTROL_ADDR || reg_addr == REG_REMOTE_DES_ADDR);
   assign lim = ctl_q[1] ? WDOG_SHORT_CYCLES : WDOG_LONG_CYCLES;

   // Shadow state; a refused write leaves the control bits alone
   always_ff @(posedge core_clk) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (rst) begin
         ctl_q  <= 5'h00;
         fall_q <= 0;
         idle_q <= 0;
         rel_q  <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == REG_I2C_CONTROL_ADDR && !rej_wr) ctl_q <= reg_wdata[4:0];
         fall_q <= (scl_q && !scl_i) ? 0 : fall_q + 1;
         idle_q <= (scl_q != scl_i || sda_q != sda_i || ctl_q[0]) ? 0 : idle_q + 1;
         if ($rose(bus_recovering)) rel_q <= 4'h0;
         else if ($rose(scl_oe_n)) rel_q <= rel_q + 4'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_read_answer: assert property (reg_rd |=> reg_rdata_valid)
      else $error("read not answered");
   a_valid_pulse: assert property (!reg_rd |=> !reg_rdata_valid)
      else $error("stray read valid");
   a_remote_refused: assert property (rej_wr |=> reg_wr_rejected)
      else $error("remote write not refused");
   a_write_allowed: assert property (!rej_wr |=> !reg_wr_rejected)
      else $error("write refused wrongly");
   a_zero_blocks: assert property (remote_access_enable == {|remote_addr_port1, |remote_addr_port0})
      else $error("access enable wrong");
   a_sda_delay: assert property ($changed(sda_oe_n) |-> fall_q == SDA_BASE_CYC + SDA_STEP_CYC * ctl_q[4:3])
      else $error("sda delay wrong");
   a_free_timeout: assert property ($rose(bus_free) |-> idle_q + 1 >= lim)
      else $error("bus free too early");
   a_free_in_time: assert property (idle_q == lim + 3 && sda_q && !ctl_q[0] |-> bus_free)
      else $error("bus free too late");
   a_free_sda_high: assert property ($rose(bus_free) |-> sda_q)
      else $error("bus free with sda low");
   a_edge_restart: assert property (scl_q != scl_i || sda_q != sda_i |=> !bus_free)
      else $error("bus free kept over activity");
   a_off_quiet: assert property (ctl_q[0] |=> !bus_free && !bus_recovering)
      else $error("watchdog active while off");
   a_recover_start: assert property ($rose(bus_recovering) |-> !scl_oe_n && !sda_q)
      else $error("recovery start wrong");
   a_nine_pulses: assert property ($fell(bus_recovering) && !ctl_q[0] |-> rel_q == 4'h8 && $rose(scl_oe_n))
      else $error("recovery pulse count wrong");

   c_refused: cover property (reg_wr_rejected);
   c_sda_moved: cover property ($changed(sda_oe_n));
   c_free: cover property ($rose(bus_free));
   c_recovered: cover property ($fell(bus_recovering));
endmodule : icc_i2c_props
bind icc_i2c_control_channel_config icc_i2c_props #(
   .WDOG_LONG_CYCLES(WDOG_LONG_CYCLES), .WDOG_SHORT_CYCLES(WDOG_SHORT_CYCLES)
) u_props (
   .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_remote, .scl_i, .sda_i,
   .scl_oe_n, .sda_oe_n, .reg_rdata_valid, .reg_wr_rejected, .remote_addr_port0,
   .remote_addr_port1, .remote_access_enable, .bus_free, .bus_recovering
);
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the I2C control block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import icc_pkg::*;
;
   localparam int unsigned LONG  = 40;  // Shortened watchdog counts keep the run brief
   localparam int unsigned SHORT = 8;
   logic       core_clk = 1'b0, rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic       reg_wr, reg_rd, reg_remote, b, prev;
   logic       second_port_select, sda_tx_data;
   logic [1:0] rx_lock, remote_access_enable;
   logic       scl_i, sda_i, scl_oe_n, sda_oe_n, reg_rdata_valid, reg_wr_rejected;
   logic       auto_addr_valid, auto_addr_port, bus_free, bus_recovering;
   logic [6:0] auto_addr, remote_addr_port0, remote_addr_port1;
   int         n_mismatch = 0, checks_done = 0, cnt, k;

   always #2.5 core_clk = ~core_clk;

   icc_i2c_control_channel_config #(.WDOG_LONG_CYCLES(LONG), .WDOG_SHORT_CYCLES(SHORT)) u_dut (
      .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_remote,
      .second_port_select, .rx_lock, .auto_addr_valid, .auto_addr_port, .auto_addr,
      .sda_tx_data, .scl_i, .sda_i, .scl_o(), .scl_oe_n, .sda_o(), .sda_oe_n, .reg_rdata,
      .reg_rdata_valid, .reg_wr_rejected, .remote_addr_port0, .remote_addr_port1,
      .remote_access_enable, .bus_free, .bus_recovering);

   icc_far_model u_far (.core_clk, .scl_oe_n, .sda_oe_n, .scl_i, .sda_i,
      .auto_addr_valid, .auto_addr_port, .auto_addr);

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // A used-up wait ends the run at once
   task automatic limit(input int c, input int lim);
      if (c >= lim) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : limit

   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask : tick

   // Write strobe lasts one edge; the refusal pulse is read right after it
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic r, output logic rj);
      @(posedge core_clk);
      reg_addr   <= a;
      reg_wdata  <= v;
      reg_remote <= r;
      reg_wr     <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
      rj = reg_wr_rejected;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read valid", 8'h01, 8'(reg_rdata_valid));
      v = reg_rdata;
   endtask : rd

   // One SCL pulse restarts the count, then wait for the bus to be judged free
   task automatic idle_wait(output int c);
      u_far.set_scl(1'b0);
      u_far.set_scl(1'b1);
      for (c = 0; c < 200 && bus_free !== 1'b1; c++) tick();
      limit(c, 200);
   endtask : idle_wait

   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      // Bench-driven inputs start idle; SDA engine level starts released
      {reg_addr, reg_wdata, reg_wr, reg_rd, reg_remote, second_port_select, rx_lock} <= '0;
      sda_tx_data <= 1'b1;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(REG_I2C_CONTROL_ADDR, d);
      chk("i2c_control", I2C_CONTROL_RST, d);
      rd(REG_REMOTE_DES_ADDR, d);
      chk("remote address", REMOTE_DES_ADDR_RST, d);
      rd(8'h07, d);
      chk("unmapped", 8'h00, d);
      wr(REG_I2C_CONTROL_ADDR, 8'hff, 1'b0, b);
      rd(REG_I2C_CONTROL_ADDR, d);
      chk("i2c_control", 8'h1f, d);
      wr(REG_REMOTE_DES_ADDR, 8'h51, 1'b1, b);
      chk("refused", 8'h01, 8'(b));
      wr(REG_I2C_CONTROL_ADDR, 8'h00, 1'b1, b);
      rd(REG_REMOTE_DES_ADDR, d);
      chk("remote address", 8'h00, d);
      rd(REG_I2C_CONTROL_ADDR, d);
      chk("remote read", 8'h1f, d);
      wr(REG_I2C_CONTROL_ADDR, 8'h01, 1'b0, b);
      wr(REG_REMOTE_DES_ADDR, 8'h51, 1'b1, b);
      chk("refused", 8'h00, 8'(b));
      chk("port0 address", 8'h28, 8'(remote_addr_port0));
      @(posedge core_clk);
      second_port_select <= 1'b1;
      wr(REG_REMOTE_DES_ADDR, 8'h66, 1'b0, b);
      rd(REG_REMOTE_DES_ADDR, d);
      chk("port1 field", 8'h66, d);
      chk("access enable", 8'h03, 8'(remote_access_enable));
      @(posedge core_clk);
      second_port_select <= 1'b0;
      rx_lock            <= 2'h3;
      rd(REG_REMOTE_DES_ADDR, d);
      chk("port0 field", 8'h51, d);
      u_far.deliver(1'b1, 7'h15);
      tick();
      chk("port1 address", 8'h15, 8'(remote_addr_port1));
      u_far.deliver(1'b0, 7'h22);
      tick();
      chk("held address", 8'h28, 8'(remote_addr_port0));
      @(posedge core_clk);
      rx_lock <= 2'h1;
      u_far.deliver(1'b1, 7'h44);
      tick();
      chk("unlocked port", 8'h15, 8'(remote_addr_port1));
      wr(REG_REMOTE_DES_ADDR, 8'h00, 1'b0, b);
      chk("access enable", 8'h02, 8'(remote_access_enable));
      u_far.deliver(1'b0, 7'h22);
      tick();
      chk("loaded address", 8'h22, 8'(remote_addr_port0));
      // Every delay code, watchdog off so it cannot interfere
      for (int c = 0; c < 4; c++) begin
         wr(REG_I2C_CONTROL_ADDR, 8'(c << 3) | 8'h01, 1'b0, b);
         u_far.set_scl(1'b0);
         sda_tx_data <= ~sda_tx_data;
         tick();
         for (cnt = 1; cnt < 200 && sda_oe_n !== sda_tx_data; cnt++) tick();
         chk("sda delay", 8'(SDA_BASE_CYC + SDA_STEP_CYC * c + 1), 8'(cnt));
         chk("sda line", 8'(sda_tx_data), 8'(sda_i));
         u_far.set_scl(1'b1);
      end
      wr(REG_I2C_CONTROL_ADDR, 8'h02, 1'b0, b);
      idle_wait(cnt);
      chk("short timeout", 8'h01, 8'(cnt >= SHORT - 1 && cnt <= SHORT + 3));
      u_far.set_scl(1'b0);
      tick();
      chk("free after edge", 8'h00, 8'(bus_free));
      u_far.set_scl(1'b1);
      wr(REG_I2C_CONTROL_ADDR, 8'h00, 1'b0, b);
      idle_wait(cnt);
      chk("long timeout", 8'h01, 8'(cnt >= LONG - 1 && cnt <= LONG + 3));
      repeat (4) tick();  // Idle past the timeout so the late-free check is reached
      // Hung bus while switched off: nothing may happen
      wr(REG_I2C_CONTROL_ADDR, 8'h01, 1'b0, b);
      u_far.set_sda(1'b0);
      repeat (2 * LONG) tick();
      chk("watchdog off", 8'h00, {6'h00, bus_free, bus_recovering});
      wr(REG_I2C_CONTROL_ADDR, 8'h02, 1'b0, b);
      for (cnt = 0; cnt < 100 && bus_recovering !== 1'b1; cnt++) tick();
      limit(cnt, 100);
      chk("scl pulled", 8'h00, 8'(scl_i));
      for (cnt = 1, k = 0; k < 30000 && bus_recovering === 1'b1; k++) begin
         prev = scl_oe_n;
         tick();
         if (prev === 1'b1 && scl_oe_n === 1'b0) cnt++;
      end
      limit(k, 30000);
      u_far.set_sda(1'b1);
      chk("recovery pulses", 8'h09, 8'(cnt));
      chk("scl released", 8'h01, 8'(scl_oe_n));
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
